// >>> design/fcu_pinproto.v
// error output pin protocol generator
`timescale 1ns/100ps
`include "fcu_consts.vh"
module fcu_pinproto (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // control
  input  wire [1:0]  proto,
  input  wire        fast,
  input  wire        polarity,
  input  wire        pin_select,
  input  wire        fail_ind,
  input  wire [15:0] period_us,
  // pins
  output reg         pin_a,
  output reg         pin_b
);
  reg [15:0] us_cnt_q;
  reg [4:0]  pre_q;
  reg        phase_q;
  wire [15:0] half = (fast ? 16'h0040 : period_us) >> 1;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_q    <= 5'h0;
      us_cnt_q <= 16'h0;
      phase_q  <= 1'b0;
      pin_a    <= 1'b0;
      pin_b    <= 1'b0;
    end else begin
      pre_q <= (pre_q == `FCU_US_CYC - 1) ? 5'h0 : pre_q + 5'h1;
      if (pre_q == `FCU_US_CYC - 1) begin
        if (us_cnt_q + 16'h1 >= half) begin
          us_cnt_q <= 16'h0;
          phase_q  <= ~phase_q;
        end else begin
          us_cnt_q <= us_cnt_q + 16'h1;
        end
      end
      if (fail_ind) begin
        pin_a <= polarity;
        pin_b <= polarity;
      end else begin
        case (proto)
          `FCU_PROTO_DUAL: begin
            pin_a <= phase_q;
            pin_b <= ~phase_q;
          end
          `FCU_PROTO_TSW: begin
            pin_a <= ~phase_q;
            pin_b <= phase_q;
          end
          default: begin
            pin_a <= ~pin_select;
            pin_b <= pin_select;
          end
        endcase
      end
    end
  end
endmodule

// >>> design/fcu_sync.v
// two-stage synchroniser for the fault source inputs
`timescale 1ns/100ps
module fcu_sync #(
  parameter W = 128
) (
  // clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// >>> design/fcu_top.v
// fault collection unit with error output signalling and AXI4-Lite registers
// Contract
// - two error output pins indicate internal failure externally.
// - pins driven by hardware protocol or software, never both.
// - selectable dual rail, time switching or bi-stable protocols.
// - software pin values apply only in normal or alarm state.
// - fault state forces both pins equal per polarity; writes ignored.
// - recovery returns unit to normal and restores software control.
// - readable error flag; software writes 1 fault, 0 operational.
// - after start-up reset pins indicate failure until software request.
// - operational indication keeps at least one pin high.
// - bi-stable: config bit selects which pin is high when operational.
// - fault processing completes within ten oscillator cycles.
// - dual rail and time switching fast mode show fault within 64 us.
// - bi-stable shows fault on pins within 64 us.
// - failure indication held 250 us plus programmable extension.
// - bi-stable extension programmable up to 10 ms.
// - new failure during hold restarts the hold timer.
// - each source has its own reaction: irq, nmi, reset, pin, none.
// - optionally disable communication transmit on entering fault.
// - per-source status flags in four status registers.
// - functional reset does not clear state or status flags.
`timescale 1ns/100ps
`include "fcu_consts.vh"
module fcu_top (
  // clock and start-up reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [11:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [11:0] s_axi_araddr,
  // axi4-lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // fault sources
  input  wire [127:0] fault_in,
  // reactions
  output reg         irq_out,
  output reg         nmi_out,
  output reg         reset_req,
  output reg         comm_tx_disable,
  // error output pins
  output reg         error_out_pin_a,
  output reg         error_out_pin_b
);
  // synchronised sources
  wire [127:0] flt_s;
  fcu_sync #(.W(`FCU_NSRC)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (fault_in),
    .q       (flt_s)
  );

  // registers
  reg [31:0]  ctrl_q;
  reg [1:0]   swpin_q;
  reg         err_flag_q;
  reg [15:0]  hold_ext_q;
  reg [15:0]  period_q;
  reg [127:0] status_q;
  reg [127:0] flt_d1_q;
  reg [2:0]   react_q [0:127];
  reg [1:0]   state_q;
  reg [31:0]  hold_cnt_q;
  // ctrl fields
  wire [1:0] proto     = ctrl_q[1:0];
  wire       fast      = ctrl_q[2];
  wire       polarity  = ctrl_q[3];
  wire       pin_sel   = ctrl_q[4]; // operational_pin_select
  wire       sw_mode   = ctrl_q[5];
  wire       txdis_en  = ctrl_q[6];
  wire       recover   = ctrl_q[7];

  function [3:0] strb_mask;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  s;
    integer i;
    begin
      strb_mask = 4'h0;
      for (i = 0; i < 4; i = i + 1)
        strb_mask[i] = s[i] & (old_v[8*i +: 8] != new_v[8*i +: 8]);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  s;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (s[i])
          merge[8*i +: 8] = new_v[8*i +: 8];
    end
  endfunction

  // status register window, aligned words only
  function is_stat;
    input [11:0] a;
    begin
      is_stat = (a[11:4] == (`FCU_OFS_STAT0 >> 4)) && (a[1:0] == 2'h0);
    end
  endfunction

  // reaction register window, aligned words only
  function is_react;
    input [11:0] a;
    begin
      is_react = (a >= `FCU_OFS_REACT0) && (a < `FCU_OFS_REACT_END) && (a[1:0] == 2'h0);
    end
  endfunction

  // source index of a reaction register, first word is index 0
  function [6:0] react_index;
    input [11:0] a;
    begin
      react_index = a[8:2] - 7'h10;
    end
  endfunction

  // any register that answers with okay
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `FCU_OFS_CTRL) || (a == `FCU_OFS_SWPIN) || (a == `FCU_OFS_STATE) ||
                  (a == `FCU_OFS_HOLDEXT) || (a == `FCU_OFS_PERIOD) || is_stat(a) || is_react(a);
    end
  endfunction

  // write channel capture
  reg        aw_got_q;
  reg        w_got_q;
  reg [11:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  wire       wr_go = aw_got_q & w_got_q & ~s_axi_bvalid;
  wire [6:0] wsrc  = aw_addr_q[8:2];
  wire       wr_react  = wr_go && is_react(aw_addr_q);
  wire       wr_stat   = wr_go && is_stat(aw_addr_q);
  wire [6:0] react_idx = react_index(aw_addr_q);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 12'h0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_got_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_got_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr_q) ? 2'h0 : 2'h2;
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // reaction decode
  reg  [127:0] new_ev;
  reg          ev_pin;
  reg          ev_irq;
  reg          ev_nmi;
  reg          ev_rst;
  integer k;
  always @* begin
    new_ev = flt_s & ~flt_d1_q;
    ev_pin = 1'b0;
    ev_irq = 1'b0;
    ev_nmi = 1'b0;
    ev_rst = 1'b0;
    for (k = 0; k < `FCU_NSRC; k = k + 1) begin
      if (new_ev[k]) begin
        case (react_q[k])
          `FCU_RX_IRQ:   ev_irq = 1'b1;
          `FCU_RX_NMI:   ev_nmi = 1'b1;
          `FCU_RX_RESET: ev_rst = 1'b1;
          `FCU_RX_PIN:   ev_pin = 1'b1;
          default:       ev_pin = ev_pin;
        endcase
      end
    end
  end

  wire        sw_fail  = wr_go && aw_addr_q == `FCU_OFS_STATE && w_strb_q[0] && w_data_q[0];
  wire        sw_clear = wr_go && aw_addr_q == `FCU_OFS_STATE && w_strb_q[0] && !w_data_q[0];
  wire        fail_ev  = ev_pin | sw_fail;
  wire [31:0] hold_tgt = `FCU_HOLD_BASE_CYC + hold_ext_q * `FCU_US_CYC;
  wire        hold_done = hold_cnt_q >= hold_tgt;

  // state, status and config
  integer j;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= `FCU_CTRL_RST;
      swpin_q    <= 2'h3;
      err_flag_q <= 1'b1;
      hold_ext_q <= 16'h0;
      period_q   <= `FCU_PERIOD_RST;
      status_q   <= 128'h0;
      flt_d1_q   <= 128'h0;
      state_q    <= `FCU_ST_FAULT;
      hold_cnt_q <= 32'h0;
      for (j = 0; j < `FCU_NSRC; j = j + 1)
        react_q[j] <= `FCU_RX_PIN;
    end else begin
      flt_d1_q <= flt_s;
      if (wr_go) begin
        case (aw_addr_q)
          `FCU_OFS_CTRL:    ctrl_q  <= merge(ctrl_q, w_data_q, w_strb_q);
          `FCU_OFS_SWPIN:   swpin_q <= w_strb_q[0] ? w_data_q[1:0] : swpin_q;
          `FCU_OFS_HOLDEXT: hold_ext_q <= (w_data_q[15:0] > `FCU_EXT_MAX_US) ? 16'd10000 : w_data_q[15:0];
          `FCU_OFS_PERIOD:  period_q <= (w_data_q[15:0] < `FCU_PERIOD_MIN_US) ? 16'd128 : w_data_q[15:0];
          default:          ctrl_q <= ctrl_q;
        endcase
        if (wr_react)
          react_q[react_idx] <= w_data_q[2:0];
      end
      // status: write one to clear, new event wins
      for (j = 0; j < `FCU_NSRC; j = j + 1)
        status_q[j] <= new_ev[j] | (status_q[j] & ~(wr_stat && wsrc[1:0] == j / 32 && w_data_q[j % 32]));
      if (fail_ev) begin
        err_flag_q <= 1'b1;
        state_q    <= `FCU_ST_FAULT;
        hold_cnt_q <= 32'h0;
      end else begin
        if (!hold_done)
          hold_cnt_q <= hold_cnt_q + 32'h1;
        if (sw_clear)
          err_flag_q <= 1'b0;
        if (state_q == `FCU_ST_FAULT && !err_flag_q && hold_done)
          state_q <= `FCU_ST_NORMAL;
        else if (state_q != `FCU_ST_FAULT)
          state_q <= (ev_irq | ev_nmi) ? `FCU_ST_ALARM : (recover ? `FCU_ST_NORMAL : state_q);
      end
    end
  end

  // protocol generator
  wire hw_a;
  wire hw_b;
  wire fault_now = (state_q == `FCU_ST_FAULT);
  fcu_pinproto u_proto (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .proto      (proto),
    .fast       (fast),
    .polarity   (polarity),
    .pin_select (pin_sel),
    .fail_ind   (fault_now),
    .period_us  (period_q),
    .pin_a      (hw_a),
    .pin_b      (hw_b)
  );

  // pin and reaction outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      error_out_pin_a <= 1'b0;
      error_out_pin_b <= 1'b0;
      irq_out         <= 1'b0;
      nmi_out         <= 1'b0;
      reset_req       <= 1'b0;
      comm_tx_disable <= 1'b0;
    end else begin
      if (sw_mode && !fault_now) begin
        error_out_pin_a <= swpin_q[0];
        error_out_pin_b <= swpin_q[1] | ~swpin_q[0];
      end else begin
        error_out_pin_a <= hw_a;
        error_out_pin_b <= hw_b;
      end
      irq_out         <= ev_irq;
      nmi_out         <= ev_nmi;
      reset_req       <= ev_rst;
      comm_tx_disable <= txdis_en & fault_now;
    end
  end

  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `FCU_OFS_CTRL:    s_axi_rdata <= ctrl_q;
          `FCU_OFS_SWPIN:   s_axi_rdata <= {30'h0, swpin_q};
          `FCU_OFS_STATE:   s_axi_rdata <= {27'h0, hold_done, state_q, 1'b0, err_flag_q};
          `FCU_OFS_HOLDEXT: s_axi_rdata <= {16'h0, hold_ext_q};
          `FCU_OFS_PERIOD:  s_axi_rdata <= {16'h0, period_q};
          default: begin
            if (is_stat(s_axi_araddr)) begin
              s_axi_rdata <= status_q[32*s_axi_araddr[3:2] +: 32];
            end else if (is_react(s_axi_araddr)) begin
              s_axi_rdata <= {29'h0, react_q[react_index(s_axi_araddr)]};
            end else begin
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= 2'h2;
            end
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// >>> pkg/fcu_consts.vh
// constants for the fault collection and error output block
`ifndef FCU_CONSTS_VH
`define FCU_CONSTS_VH
`define FCU_NSRC          128
`define FCU_CLK_MHZ       20
`define FCU_HOLD_BASE_US  250
`define FCU_EXT_MAX_US    10000
`define FCU_PERIOD_MIN_US 128
`define FCU_FAST_MAX_US   64
`define FCU_HOLD_BASE_CYC (`FCU_HOLD_BASE_US * `FCU_CLK_MHZ)
`define FCU_US_CYC        `FCU_CLK_MHZ
`define FCU_OFS_CTRL      12'h000
`define FCU_OFS_SWPIN     12'h004
`define FCU_OFS_STATE     12'h008
`define FCU_OFS_HOLDEXT   12'h00C
`define FCU_OFS_PERIOD    12'h010
`define FCU_OFS_STAT0     12'h020
`define FCU_OFS_REACT0    12'h040
`define FCU_OFS_REACT_END 12'h240
`define FCU_CTRL_RST      32'h0000_0000
`define FCU_PERIOD_RST    16'h0080
`define FCU_PROTO_DUAL    2'h0
`define FCU_PROTO_TSW     2'h1
`define FCU_PROTO_BIST    2'h2
`define FCU_RX_NONE       3'h0
`define FCU_RX_IRQ        3'h1
`define FCU_RX_NMI        3'h2
`define FCU_RX_RESET      3'h3
`define FCU_RX_PIN        3'h4
`define FCU_ST_NORMAL     2'h0
`define FCU_ST_ALARM      2'h1
`define FCU_ST_FAULT      2'h2
`endif

// >>> verification/fcu_sup.sv
// external supervisor model watching the error output pins
`timescale 1ns/100ps
module fcu_sup (
  // pins
  input  wire error_out_pin_a,
  input  wire error_out_pin_b,
  // verdict
  output wire fail_seen
);
  // equal levels on both pins read as failure indication
  assign fail_seen = (error_out_pin_a == error_out_pin_b);
endmodule

// >>> verification/fcu_top_asserts.sv
// port assertions for the fault collection unit
`timescale 1ns/100ps
module fcu_top_asserts (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // bus answers
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // reactions and pins
  input wire        irq_out,
  input wire        nmi_out,
  input wire        reset_req,
  input wire        comm_tx_disable,
  input wire        error_out_pin_a,
  input wire        error_out_pin_b
);
  localparam int HOLD = 5000;
  logic [12:0] eq_cnt_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles the pins have shown equal levels
  always @(posedge aclk) begin
    if (!aresetn || error_out_pin_a != error_out_pin_b) eq_cnt_q <= 13'h0000;
    else if (eq_cnt_q != 13'h1fff) eq_cnt_q <= eq_cnt_q + 13'h0001;
  end
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data changed while waiting");
  property p_rans; s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_irq; irq_out |=> !irq_out; endproperty
  a_irq: assert property (p_irq) else $error("irq pulse too long");
  property p_nmi; nmi_out |=> !nmi_out; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi pulse too long");
  property p_rst; reset_req |=> !reset_req; endproperty
  a_rst: assert property (p_rst) else $error("reset request pulse too long");
  property p_txdis; comm_tx_disable |-> ##[0:9] (error_out_pin_a == error_out_pin_b); endproperty
  a_txdis: assert property (p_txdis) else $error("tx disabled without fault pins");
  property p_hold;
    (error_out_pin_a != error_out_pin_b) && $past(error_out_pin_a == error_out_pin_b) |-> $past(eq_cnt_q) >= HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("failure indication shorter than hold");
endmodule
bind fcu_top fcu_top_asserts u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .irq_out, .nmi_out, .reset_req, .comm_tx_disable,
  .error_out_pin_a, .error_out_pin_b);

// >>> verification/tb.sv
// self-checking testbench for the fault collection unit
`timescale 1ns/100ps
`include "fcu_consts.vh"
module tb;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, d;
  logic [3:0]   s_axi_wstrb;
  logic [127:0] fault_in;
  logic [1:0]   resp;
  wire          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fail_seen;
  wire          irq_out, nmi_out, reset_req, comm_tx_disable, error_out_pin_a, error_out_pin_b;
  wire  [1:0]   s_axi_bresp, s_axi_rresp;
  wire  [31:0]  s_axi_rdata;
  int           n_mismatch, num_checks, k, s, c;
  int           pc[4];
  fcu_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .fault_in, .irq_out, .nmi_out,
    .reset_req, .comm_tx_disable, .error_out_pin_a, .error_out_pin_b);
  fcu_sup sup (.error_out_pin_a, .error_out_pin_b, .fail_seen);
  initial aclk = 1'b0;
  always #25 aclk = ~aclk;
  // count reaction pulses
  always @(posedge aclk) begin
    if (irq_out) pc[1]++;
    if (nmi_out) pc[2]++;
    if (reset_req) pc[3]++;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // both pins at the polarity level in fault
  function automatic logic [31:0] fault_pins(input logic pol);
    return pol ? 32'h0000_0003 : 32'h0000_0000;
  endfunction
  task wr(input logic [11:0] a, input logic [31:0] v);
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && t < 200);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (t >= 200) n_mismatch++;
  endtask
  task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
    int t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && t < 200);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (t >= 200) n_mismatch++;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    fault_in = '0;
    pc = '{default: 0};
    k = $urandom(32'h150345da);
    k = $urandom_range(0, 117);
    cyc(3);
    aresetn <= 1'b1;
    cyc(2);
    chk("pins_reset", 32'h0000_0000, {error_out_pin_a, error_out_pin_b});
    rd(`FCU_OFS_STATE, d, resp);
    chk("state_reset", 32'h0000_0009, d & 32'h0000_000d);
    rd(`FCU_OFS_REACT0, d, resp);
    chk("react_reset", 32'h0000_0004, d & 32'h0000_0007);
    rd(12'h018, d, resp);
    chk("unmapped", 32'h0000_0002, {30'h0, resp});
    wr(12'h018, 32'h0000_0000);
    chk("wr_unmapped", 32'h0000_0002, {30'h0, resp});
    wr(`FCU_OFS_PERIOD, 32'h0000_0080);
    chk("wr_okay", 32'h0000_0000, {30'h0, resp});
    wr(`FCU_OFS_STATE, 32'h0000_0000);
    cyc(4500);
    chk("pins_held", 32'h0000_0000, {error_out_pin_a, error_out_pin_b});
    cyc(700);
    chk("pins_op", 32'h0000_0000, fail_seen);
    rd(`FCU_OFS_STATE, d, resp);
    chk("state_normal", 32'h0000_0000, d & 32'h0000_000d);
    for (c = 0; c < 3; c++) begin
      wr(`FCU_OFS_CTRL, c | 32'h0000_0004);
      cyc(20);
      chk("proto_op", 32'h0000_0001, error_out_pin_a | error_out_pin_b);
    end
    wr(`FCU_OFS_CTRL, 32'h0000_0002);
    cyc(20);
    chk("sel_zero", 32'h0000_0002, {error_out_pin_a, error_out_pin_b});
    wr(`FCU_OFS_CTRL, 32'h0000_0012);
    cyc(20);
    chk("sel_swap", 32'h0000_0001, {error_out_pin_a, error_out_pin_b});
    chk("sel_one", 32'h0000_0001, error_out_pin_a ^ error_out_pin_b);
    wr(`FCU_OFS_SWPIN, 32'h0000_0000);
    wr(`FCU_OFS_CTRL, 32'h0000_0060);
    cyc(5);
    chk("sw_pins", 32'h0000_0001, {error_out_pin_a, error_out_pin_b});
    wr(`FCU_OFS_HOLDEXT, 32'h0000_ffff);
    rd(`FCU_OFS_HOLDEXT, d, resp);
    chk("ext_clamp", 32'h0000_2710, d);
    wr(`FCU_OFS_HOLDEXT, 32'h0000_0032);
    fault_in[k] <= 1'b1;
    cyc(10);
    chk("pins_fault", fault_pins(1'b0), {error_out_pin_a, error_out_pin_b});
    chk("tx_disable", 32'h0000_0001, comm_tx_disable);
    wr(`FCU_OFS_SWPIN, 32'h0000_0001);
    cyc(3);
    chk("sw_in_fault", 32'h0000_0000, {error_out_pin_a, error_out_pin_b});
    rd(`FCU_OFS_STAT0 + 12'(4 * (k / 32)), d, resp);
    chk("status", 32'h0000_0001, d[k%32]);
    wr(`FCU_OFS_STATE, 32'h0000_0000);
    cyc(1000);
    fault_in[k+1] <= 1'b1;
    wr(`FCU_OFS_STATE, 32'h0000_0000);
    cyc(5500);
    chk("hold_restart", 32'h0000_0001, fail_seen);
    cyc(700);
    chk("recovered", 32'h0000_0000, fail_seen);
    for (c = 0; c < 4; c++) begin
      s = k + 2 + c;
      wr(`FCU_OFS_REACT0 + 12'(4 * s), c);
      fault_in[s] <= 1'b1;
      cyc(10);
      chk("react_pins", 32'h0000_0000, fail_seen);
    end
    for (c = 1; c < 4; c++) chk("react_pulse", 32'h0000_0001, pc[c]);
    wr(`FCU_OFS_CTRL, 32'h0000_0068);
    fault_in[k+10] <= 1'b1;
    cyc(10);
    chk("pins_pol", fault_pins(1'b1), {error_out_pin_a, error_out_pin_b});
    tally_and_finish;
  end
endmodule
